/* hw/adcsq_params.svh */
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH

// CPU byte addresses, lower 20 bits
`define ADCSQ_ADDR_RES_A_HI   20'hfffe0
`define ADCSQ_ADDR_RES_A_LO   20'hfffe1
`define ADCSQ_ADDR_RES_B_HI   20'hfffe2
`define ADCSQ_ADDR_RES_B_LO   20'hfffe3
`define ADCSQ_ADDR_RES_C_HI   20'hfffe4
`define ADCSQ_ADDR_RES_C_LO   20'hfffe5
`define ADCSQ_ADDR_RES_D_HI   20'hfffe6
`define ADCSQ_ADDR_RES_D_LO   20'hfffe7
`define ADCSQ_ADDR_CTRL       20'hfffe8
`define ADCSQ_ADDR_TRIG       20'hfffe9

// Control/status field positions
`define ADCSQ_CSR_END_FLAG    7
`define ADCSQ_CSR_IRQ_EN      6
`define ADCSQ_CSR_START       5
`define ADCSQ_CSR_SCAN        4
`define ADCSQ_CSR_SPEED       3
`define ADCSQ_CSR_GROUP       2

// Trigger control field positions
`define ADCSQ_TRG_ENABLE      7
`define ADCSQ_TRG_SPARE       0

// Reset values
`define ADCSQ_CSR_RESET       8'h00
`define ADCSQ_TRG_RESET       8'h7e
`define ADCSQ_TRG_FIXED_ONES  6'h3f
`define ADCSQ_RES_RESET       10'h000
`define ADCSQ_UNMAPPED_READ   8'hff

// Conversion lengths in states; one state is one clk cycle
`define ADCSQ_STATE_CYCLES    1
`define ADCSQ_SLOW_FIRST_ST   134
`define ADCSQ_FAST_FIRST_ST   70
`define ADCSQ_SLOW_NEXT_ST    128
`define ADCSQ_FAST_NEXT_ST    66
`define ADCSQ_SLOW_FIRST_CYC  (`ADCSQ_SLOW_FIRST_ST * `ADCSQ_STATE_CYCLES)
`define ADCSQ_FAST_FIRST_CYC  (`ADCSQ_FAST_FIRST_ST * `ADCSQ_STATE_CYCLES)
`define ADCSQ_SLOW_NEXT_CYC   (`ADCSQ_SLOW_NEXT_ST * `ADCSQ_STATE_CYCLES)
`define ADCSQ_FAST_NEXT_CYC   (`ADCSQ_FAST_NEXT_ST * `ADCSQ_STATE_CYCLES)

`endif

/* hw/adcsq_pkg.sv */
package adcsq_pkg;

   typedef struct packed
   {
      logic [19:0] addr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
   } adcsq_bus_s;

   typedef struct packed
   {
      logic       start;
      logic [2:0] channel;
      logic       fast;
   } adcsq_core_s;

   typedef enum logic [0:0]
   {
      ADCSQ_IDLE = 1'b0,
      ADCSQ_CONV = 1'b1
   } adcsq_state_e;

   typedef logic [7:0] adcsq_count_t;

endpackage

/* hw/adcsq_result_reg.sv */
`timescale 1ns/100ps
`include "adcsq_params.svh"

module adcsq_result_reg
(
   input  wire logic        clk,    // System clock
   input  wire logic        rst_n,  // Async reset, active low
   input  wire logic        clear,  // Standby clear
   input  wire logic        load,   // Store new result
   input  wire logic [9:0]  data,   // Conversion result
   output logic      [15:0] value   // Stored word, low six bits zero
);

   logic [9:0] res_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         res_r <= `ADCSQ_RES_RESET;
      end
      else if (clear)
      begin
         res_r <= `ADCSQ_RES_RESET;
      end
      else if (load)
      begin
         res_r <= data;
      end
   end

   assign value = {res_r, 6'h00};

endmodule // adcsq_result_reg

/* hw/adcsq_top.sv */
// What this block does
// - Each result goes to register A-D by channel modulo four.
// - Upper eight result bits in high byte, low two in byte bits 7-6.
// - Result register bits 5 to 0 always read zero.
// - Result registers clear on reset and on standby.
// - High byte read directly; low byte comes through a holding register.
// - High byte read copies low byte to holding; read high first.
// - Results readable at any time, also during conversion.
// - Control/status register clears on reset and on standby.
// - End flag sets after single conversion or after whole scan group.
// - End flag clears by writing zero after reading it as one.
// - Interrupt asserted while end flag and interrupt enable are both one.
// - Start bit set by software, trigger pin or timer; reads one while busy.
// - Single mode converts one channel then clears start bit.
// - Scan mode rotates channels until start bit cleared or standby.
// - Every scan and restart begins at the group's lowest channel.
// - Bit 4 selects single or scan mode.
// - Bit 3 selects 134-state or 70-state conversion.
// - Bit 2 selects group; bits 1-0 pick channel or scan count.
// - Trigger enable gates pin falling edge and timer match starts.
`timescale 1ns/100ps
`include "adcsq_params.svh"

module adcsq_top
(
   input  wire logic                   clk,             // System clock, 20 MHz
   input  wire logic                   rst_n,           // Async reset, active low
   input  wire logic                   standby,         // Standby level, clears block
   input  wire adcsq_pkg::adcsq_bus_s  bus,             // CPU byte bus request
   output logic                 [7:0]  rdata,           // CPU read data
   input  wire logic                   ext_trigger_pin, // External trigger pin
   input  wire logic                   timer_match,     // Timer compare match pulse
   output adcsq_pkg::adcsq_core_s      core,            // Converter core control
   input  wire logic            [9:0]  core_result,     // Converter core result
   output logic                        conv_end_irq     // End-of-conversion request
);

   import adcsq_pkg::*;

   localparam adcsq_count_t SLOW_FIRST = adcsq_count_t'(`ADCSQ_SLOW_FIRST_CYC - 1);
   localparam adcsq_count_t FAST_FIRST = adcsq_count_t'(`ADCSQ_FAST_FIRST_CYC - 1);
   localparam adcsq_count_t SLOW_NEXT  = adcsq_count_t'(`ADCSQ_SLOW_NEXT_CYC - 1);
   localparam adcsq_count_t FAST_NEXT  = adcsq_count_t'(`ADCSQ_FAST_NEXT_CYC - 1);

   logic          end_flag_r;
   logic          flag_armed_r;
   logic          irq_en_r;
   logic          start_r;
   logic          scan_r;
   logic          speed_r;
   logic [2:0]    chan_sel_r;
   logic          trig_en_r;
   logic          trig_spare_r;
   logic [7:0]    temp_r;
   logic [7:0]    rdata_r;
   logic          trig_s1_r;
   logic          trig_s2_r;
   logic          trig_s3_r;
   adcsq_state_e  state_r;
   adcsq_count_t  cnt_r;
   logic [1:0]    pos_r;
   logic          core_start_r;
   logic [2:0]    core_chan_r;
   logic [15:0]   res_value [4];
   logic [3:0]    res_load;

   logic          ctrl_wr;
   logic          ctrl_rd;
   logic          trig_wr;
   logic          res_rd;
   logic [1:0]    res_idx;
   logic          pin_fall;
   logic          hw_start;
   logic          conv_done;
   logic          scan_last;
   logic          flag_set;
   logic          single_done;
   logic [1:0]    cur_pos;
   logic [7:0]    csr_value;
   logic [7:0]    trg_value;

   // Address decode
   assign ctrl_wr = bus.wr && (bus.addr == `ADCSQ_ADDR_CTRL);
   assign ctrl_rd = bus.rd && (bus.addr == `ADCSQ_ADDR_CTRL);
   assign trig_wr = bus.wr && (bus.addr == `ADCSQ_ADDR_TRIG);
   assign res_rd  = bus.rd && (bus.addr >= `ADCSQ_ADDR_RES_A_HI) && (bus.addr <= `ADCSQ_ADDR_RES_D_LO);
   assign res_idx = bus.addr[2:1];

   // Trigger pin synchroniser and falling edge
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trig_s1_r <= 1'b1;
         trig_s2_r <= 1'b1;
         trig_s3_r <= 1'b1;
      end
      else
      begin
         trig_s1_r <= ext_trigger_pin;
         trig_s2_r <= trig_s1_r;
         trig_s3_r <= trig_s2_r;
      end
   end

   assign pin_fall = trig_s3_r && !trig_s2_r;
   assign hw_start = trig_en_r && (pin_fall || timer_match);

   // Sequencer events
   assign cur_pos     = scan_r ? pos_r : chan_sel_r[1:0];
   assign conv_done   = (state_r == ADCSQ_CONV) && start_r && (cnt_r == '0);
   assign scan_last   = pos_r == chan_sel_r[1:0];
   assign single_done = conv_done && !scan_r;
   assign flag_set    = conv_done && (!scan_r || scan_last);

   // Control bits of the control/status register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_en_r   <= 1'b0;
         scan_r     <= 1'b0;
         speed_r    <= 1'b0;
         chan_sel_r <= 3'h0;
      end
      else if (standby)
      begin
         irq_en_r   <= 1'b0;
         scan_r     <= 1'b0;
         speed_r    <= 1'b0;
         chan_sel_r <= 3'h0;
      end
      else if (ctrl_wr)
      begin
         irq_en_r   <= bus.wdata[`ADCSQ_CSR_IRQ_EN];
         scan_r     <= bus.wdata[`ADCSQ_CSR_SCAN];
         speed_r    <= bus.wdata[`ADCSQ_CSR_SPEED];
         chan_sel_r <= bus.wdata[2:0];
      end
   end

   // Start bit; a set while already one leaves the sequence alone
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         start_r <= 1'b0;
      end
      else if (standby)
      begin
         start_r <= 1'b0;
      end
      else if (!start_r && ((ctrl_wr && bus.wdata[`ADCSQ_CSR_START]) || hw_start))
      begin
         start_r <= 1'b1;
      end
      else if (ctrl_wr && !bus.wdata[`ADCSQ_CSR_START])
      begin
         start_r <= 1'b0;
      end
      else if (single_done)
      begin
         start_r <= 1'b0;
      end
   end

   // End flag; a set in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         end_flag_r   <= 1'b0;
         flag_armed_r <= 1'b0;
      end
      else if (standby)
      begin
         end_flag_r   <= 1'b0;
         flag_armed_r <= 1'b0;
      end
      else if (flag_set)
      begin
         end_flag_r <= 1'b1;
      end
      else if (ctrl_wr && !bus.wdata[`ADCSQ_CSR_END_FLAG] && flag_armed_r)
      begin
         end_flag_r   <= 1'b0;
         flag_armed_r <= 1'b0;
      end
      else if (ctrl_rd && end_flag_r)
      begin
         flag_armed_r <= 1'b1;
      end
   end

   // Trigger control register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trig_en_r    <= 1'(`ADCSQ_TRG_RESET >> `ADCSQ_TRG_ENABLE);
         trig_spare_r <= 1'b0;
      end
      else if (standby)
      begin
         trig_en_r    <= 1'b0;
         trig_spare_r <= 1'b0;
      end
      else if (trig_wr)
      begin
         trig_en_r    <= bus.wdata[`ADCSQ_TRG_ENABLE];
         trig_spare_r <= bus.wdata[`ADCSQ_TRG_SPARE];
      end
   end

   // Conversion sequencer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ADCSQ_IDLE;
         cnt_r   <= '0;
         pos_r   <= 2'h0;
      end
      else if (standby || !start_r)
      begin
         state_r <= ADCSQ_IDLE;
         cnt_r   <= '0;
         pos_r   <= 2'h0;
      end
      else
      begin
         unique case (state_r)
            ADCSQ_IDLE:
            begin
               state_r <= ADCSQ_CONV;
               cnt_r   <= speed_r ? FAST_FIRST : SLOW_FIRST;
               pos_r   <= 2'h0;
            end
            ADCSQ_CONV:
            begin
               if (cnt_r != '0)
               begin
                  cnt_r <= cnt_r - 1'b1;
               end
               else if (!scan_r)
               begin
                  state_r <= ADCSQ_IDLE;
               end
               else
               begin
                  cnt_r <= speed_r ? FAST_NEXT : SLOW_NEXT;
                  pos_r <= scan_last ? 2'h0 : pos_r + 2'h1;
               end
            end
         endcase
      end
   end

   // Core control outputs
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         core_start_r <= 1'b0;
         core_chan_r  <= 3'h0;
      end
      else
      begin
         core_start_r <= !standby && start_r &&
                         ((state_r == ADCSQ_IDLE) || (conv_done && scan_r));
         if ((state_r == ADCSQ_IDLE) && start_r)
         begin
            core_chan_r <= {chan_sel_r[2], scan_r ? 2'h0 : chan_sel_r[1:0]};
         end
         else if (conv_done && scan_r)
         begin
            core_chan_r <= {chan_sel_r[2], scan_last ? 2'h0 : pos_r + 2'h1};
         end
      end
   end

   assign core.start   = core_start_r;
   assign core.channel = core_chan_r;
   assign core.fast    = speed_r;

   // Result storage, one register per channel pair
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_res
         assign res_load[gi] = conv_done && !standby && (cur_pos == 2'(gi));
         adcsq_result_reg u_res
         (
            .clk   (clk),
            .rst_n (rst_n),
            .clear (standby),
            .load  (res_load[gi]),
            .data  (core_result),
            .value (res_value[gi])
         );
      end
   endgenerate

   assign csr_value = {end_flag_r, irq_en_r, start_r, scan_r, speed_r, chan_sel_r};
   assign trg_value = {trig_en_r, `ADCSQ_TRG_FIXED_ONES, trig_spare_r};

   // Holding register for low result bytes
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         temp_r <= 8'h00;
      end
      else if (standby)
      begin
         temp_r <= 8'h00;
      end
      else if (res_rd && !bus.addr[0])
      begin
         temp_r <= res_value[res_idx][7:0];
      end
   end

   // Read data, registered one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_r <= 8'h00;
      end
      else if (bus.rd)
      begin
         if (res_rd)
         begin
            rdata_r <= bus.addr[0] ? temp_r : res_value[res_idx][15:8];
         end
         else if (bus.addr == `ADCSQ_ADDR_CTRL)
         begin
            rdata_r <= csr_value;
         end
         else if (bus.addr == `ADCSQ_ADDR_TRIG)
         begin
            rdata_r <= trg_value;
         end
         else
         begin
            rdata_r <= `ADCSQ_UNMAPPED_READ;
         end
      end
   end

   assign rdata        = rdata_r;
   assign conv_end_irq = end_flag_r && irq_en_r;

   property p_irq_follows;
      @(posedge clk) disable iff (!rst_n)
      (flag_set && irq_en_r && !standby && !ctrl_wr) |=> conv_end_irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch");

   property p_single_end;
      @(posedge clk) disable iff (!rst_n)
      (single_done && !standby) |=> (end_flag_r && !start_r);
   endproperty
   a_single_end: assert property (p_single_end) else $error("single end wrong");

   property p_low_zero;
      @(posedge clk) disable iff (!rst_n)
      (bus.rd && res_rd && !bus.addr[0]) |=> (temp_r[5:0] == 6'h00);
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("low bits not zero");

   property p_standby_clear;
      @(posedge clk) disable iff (!rst_n)
      standby |=> (csr_value == `ADCSQ_CSR_RESET) && (res_value[0] == 16'h0000) && (res_value[3] == 16'h0000);
   endproperty
   a_standby_clear: assert property (p_standby_clear) else $error("standby clear failed");

   property p_trig_ignored;
      @(posedge clk) disable iff (!rst_n)
      (!trig_en_r && !start_r && !ctrl_wr && !standby) |=> !start_r;
   endproperty
   a_trig_ignored: assert property (p_trig_ignored) else $error("start without enable");

   property p_slow_len;
      @(posedge clk) disable iff (!rst_n)
      ($rose(state_r == ADCSQ_CONV) && !speed_r) |-> (cnt_r == 8'd133);
   endproperty
   a_slow_len: assert property (p_slow_len) else $error("slow length wrong");

   property p_fast_len;
      @(posedge clk) disable iff (!rst_n)
      ($rose(state_r == ADCSQ_CONV) && speed_r) |-> (cnt_r == 8'd69);
   endproperty
   a_fast_len: assert property (p_fast_len) else $error("fast length wrong");

   property p_high_copy;
      @(posedge clk) disable iff (!rst_n)
      (res_rd && !bus.addr[0] && !standby) |=> (temp_r == $past(res_value[res_idx][7:0]));
   endproperty
   a_high_copy: assert property (p_high_copy) else $error("holding copy wrong");

   property p_scan_start;
      @(posedge clk) disable iff (!rst_n)
      (state_r == ADCSQ_IDLE && start_r && !standby) |=> (pos_r == 2'h0) ##1 core_chan_r[1:0] == 2'h0 || !scan_r;
   endproperty
   a_scan_start: assert property (p_scan_start) else $error("scan not at first channel");

   property p_flag_hold;
      @(posedge clk) disable iff (!rst_n)
      (end_flag_r && !flag_armed_r && !standby) |=> end_flag_r;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag cleared unread");

endmodule // adcsq_top

/* verif/adc_sequencer_control_tb.sv */
`timescale 1ns/100ps
`include "adcsq_params.svh"

module adc_sequencer_control_tb;
   import adcsq_pkg::*;

   logic        clk;
   logic        rst_n;
   logic        standby;
   adcsq_bus_s  bus;
   logic  [7:0] rdata;
   logic        ext_trigger_pin;
   logic        timer_match;
   adcsq_core_s core;
   logic  [9:0] core_result;
   logic        conv_end_irq;
   logic  [6:0] salt;
   logic  [6:0] salt_old;
   logic  [7:0] v;
   logic  [7:0] ctl;
   logic        spd;
   int          num_errors;
   int          n_tests;
   int          cnt;
   int          off;

   adcsq_top i_dut (.clk(clk), .rst_n(rst_n), .standby(standby), .bus(bus), .rdata(rdata),
                    .ext_trigger_pin(ext_trigger_pin), .timer_match(timer_match), .core(core),
                    .core_result(core_result), .conv_end_irq(conv_end_irq));

   adcsq_core_model i_core (.clk(clk), .rst_n(rst_n), .core(core), .salt(salt),
                            .core_result(core_result));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [19:0] a, output logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic wait_irq(input int max, output int n);
      n = 0;
      while (conv_end_irq !== 1'b1)
      begin
         @(posedge clk);
         #1;
         n++;
         if (n > max)
         begin
            $display("mismatch irq wait expected 1 seen timeout");
            num_errors++;
            break;
         end
      end
   endtask

   // High byte first, then low byte through the holding register
   task automatic chk_res(input logic [2:0] ch, input logic [6:0] s);
      logic [19:0] a;
      logic  [7:0] d;
      a = `ADCSQ_ADDR_RES_A_HI + {ch[1:0], 1'b0};
      rd(a, d);
      chk("result high", {ch, s[6:2]}, d);
      rd(a + 20'h1, d);
      chk("result low", {s[1:0], 6'h00}, d);
   endtask

   // Read flag as one, then write zero to clear it
   task automatic clear_flag(input logic [7:0] c);
      logic [7:0] d;
      rd(`ADCSQ_ADDR_CTRL, d);
      wr(`ADCSQ_ADDR_CTRL, c & 8'h5f);
      #1;
      chk("irq after clear", 8'h00, {7'h0, conv_end_irq});
   endtask

   initial
   begin
      num_errors = 0;
      n_tests = 0;
      rst_n = 1'b0;
      standby = 1'b0;
      bus = '0;
      ext_trigger_pin = 1'b1;
      timer_match = 1'b0;
      salt = 7'h00;
      void'($urandom(32'hb95b4af8));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;

      // Reset values, read-only results, unmapped address
      wr(`ADCSQ_ADDR_RES_A_HI, 8'hff);
      for (int i = 0; i < 11; i++)
      begin
         rd(`ADCSQ_ADDR_RES_A_HI + 20'(i), v);
         chk("reset value", (i == 9) ? 8'h7e : (i == 10) ? 8'hff : 8'h00, v);
      end
      $display("test reset done");

      // Single mode on every channel
      for (int ch = 0; ch < 8; ch++)
      begin
         salt_old = salt;
         salt <= 7'($urandom);
         spd = 1'($urandom);
         ctl = 8'h60 | {4'h0, spd, 3'(ch)};
         wr(`ADCSQ_ADDR_CTRL, ctl);
         #1;
         chk("core fast", {15'h0, spd}, {15'h0, core.fast});
         off = 0;
         if (ch == 3)
         begin
            wr(`ADCSQ_ADDR_CTRL, ctl);
            off = 2;
         end
         wait_irq(300, cnt);
         chk("conv cycles", 8'((spd ? `ADCSQ_FAST_FIRST_CYC : `ADCSQ_SLOW_FIRST_CYC) + 1),
             8'(cnt + off));
         if (ch == 0)
         begin
            wr(`ADCSQ_ADDR_CTRL, (ctl & 8'h1f) | 8'h80);
            #1;
            chk("irq masked", 8'h00, {7'h0, conv_end_irq});
            wr(`ADCSQ_ADDR_CTRL, ctl & 8'h5f);
            #1;
            chk("flag unarmed", 8'h01, {7'h0, conv_end_irq});
         end
         rd(`ADCSQ_ADDR_CTRL, v);
         chk("csr after single", (ctl & 8'h5f) | 8'h80, v);
         clear_flag(ctl);
         chk_res(3'(ch), salt);
      end
      $display("test single done");

      // Scan group one, four channels
      salt <= 7'($urandom);
      spd = 1'($urandom);
      ctl = 8'h77 | {4'h0, spd, 3'h0};
      wr(`ADCSQ_ADDR_CTRL, ctl);
      repeat (20) @(posedge clk);
      rd(`ADCSQ_ADDR_CTRL, v);
      chk("csr busy", ctl, v);
      wait_irq(1000, cnt);
      chk("scan cycles", 16'((spd ? `ADCSQ_FAST_FIRST_CYC + 3 * `ADCSQ_FAST_NEXT_CYC
                                  : `ADCSQ_SLOW_FIRST_CYC + 3 * `ADCSQ_SLOW_NEXT_CYC) - 21), 16'(cnt));
      rd(`ADCSQ_ADDR_CTRL, v);
      chk("csr scan end", ctl | 8'h80, v);
      for (int ch = 4; ch < 8; ch++)
         chk_res(3'(ch), salt);
      wr(`ADCSQ_ADDR_CTRL, ctl & 8'h5f & 8'hdf);
      rd(`ADCSQ_ADDR_CTRL, v);
      chk("csr stopped", ctl & 8'h5f & 8'hdf, v);
      // Restart begins at the lowest channel of the group
      salt_old = salt;
      salt <= 7'($urandom);
      ctl = 8'h31 | {4'h0, spd, 3'h0};
      wr(`ADCSQ_ADDR_CTRL, ctl);
      repeat (spd ? `ADCSQ_FAST_FIRST_CYC + 2 : `ADCSQ_SLOW_FIRST_CYC + 2) @(posedge clk);
      rd(`ADCSQ_ADDR_RES_A_HI, v);
      chk("first of group", {3'h0, salt[6:2]}, v);
      rd(`ADCSQ_ADDR_RES_B_HI, v);
      chk("second not yet", {3'h5, salt_old[6:2]}, v);
      wr(`ADCSQ_ADDR_CTRL, 8'h00);
      $display("test scan done");

      // Hardware starts gated by trigger enable
      ctl = 8'h48;
      wr(`ADCSQ_ADDR_CTRL, ctl);
      timer_match <= 1'b1;
      @(posedge clk);
      timer_match <= 1'b0;
      ext_trigger_pin <= 1'b0;
      repeat (4) @(posedge clk);
      ext_trigger_pin <= 1'b1;
      repeat (4) @(posedge clk);
      rd(`ADCSQ_ADDR_CTRL, v);
      chk("no start when disabled", ctl, v);
      wr(`ADCSQ_ADDR_TRIG, 8'h80);
      rd(`ADCSQ_ADDR_TRIG, v);
      chk("trigger readback", 8'hfe, v);
      salt <= 7'($urandom);
      timer_match <= 1'b1;
      @(posedge clk);
      timer_match <= 1'b0;
      wait_irq(200, cnt);
      clear_flag(ctl);
      chk_res(3'h0, salt);
      @(posedge clk);
      ext_trigger_pin <= 1'b0;
      repeat (4) @(posedge clk);
      ext_trigger_pin <= 1'b1;
      wait_irq(200, cnt);
      clear_flag(ctl);
      $display("test trigger done");

      // Standby clears everything mid-scan
      wr(`ADCSQ_ADDR_TRIG, 8'h81);
      wr(`ADCSQ_ADDR_CTRL, 8'h73);
      repeat (10) @(posedge clk);
      standby <= 1'b1;
      repeat (3) @(posedge clk);
      standby <= 1'b0;
      for (int i = 0; i < 10; i++)
      begin
         rd(`ADCSQ_ADDR_RES_A_HI + 20'(i), v);
         chk("standby value", (i == 9) ? 8'h7e : 8'h00, v);
      end
      $display("test standby done");
      tally_and_finish();
   end
endmodule // adc_sequencer_control_tb

/* verif/adcsq_core_model.sv */
`timescale 1ns/100ps

module adcsq_core_model
(
   input  wire logic                   clk,         // System clock
   input  wire logic                   rst_n,       // Async reset, active low
   input  wire adcsq_pkg::adcsq_core_s core,        // Control from sequencer
   input  wire logic            [6:0]  salt,        // Low result bits from bench
   output logic                 [9:0]  core_result  // Conversion result
);
   import adcsq_pkg::*;

   logic [2:0] ch_r;
   logic       seen_r;

   // Latch channel at each conversion start
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ch_r   <= 3'h0;
         seen_r <= 1'b0;
      end
      else if (core.start)
      begin
         ch_r   <= core.channel;
         seen_r <= 1'b1;
      end
   end

   // No valid code before the first conversion
   assign core_result = seen_r ? {ch_r, salt} : ~{ch_r, salt};
endmodule // adcsq_core_model
